/* File: core/byte_stream_if.sv */
// Valid/ready byte stream between the responder and its reply FIFO.
// Assumes one clock shared by both ends.
`default_nettype none

interface byte_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: core/reply_fifo.sv */
// Reply FIFO: stores outgoing characters, read data held in a register.
// Assumes a synchronous-release active-low reset from the top module.
`default_nettype none

module reply_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   byte_stream_if.snk in_s,
   byte_stream_if.src out_s,
   output logic full,
   output logic empty
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic [WIDTH-1:0] out_q;
   logic out_valid_q;
   logic push;
   logic pop;

   assign full = (cnt_q == CW'(DEPTH));
   assign empty = (cnt_q == '0) && !out_valid_q;
   assign in_s.ready = !full;
   assign push = in_s.valid && !full;
   // Refill the output register when it is free or being taken
   assign pop = (cnt_q != '0) && (!out_valid_q || out_s.ready);
   assign out_s.valid = out_valid_q;
   assign out_s.data = out_q;

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_s.data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= '0;
         out_valid_q <= 1'b0;
      end else if (pop) begin
         out_q <= mem_q[rd_q];
         out_valid_q <= 1'b1;
      end else if (out_s.ready) begin
         out_valid_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: core/resp_params.svh */
// Constants of the serial status and monitor responder.
// Assumes inclusion by bare name from files under core/.
`ifndef RESP_PARAMS_SVH
`define RESP_PARAMS_SVH

// Frame control characters
`define CH_ENQ 8'h05
`define CH_EOT 8'h04
`define CH_ACK 8'h06
`define CH_NAK 8'h15
`define CH_ETX 8'h03
// Command letters, status command type characters and registration number digits
`define CH_STATUS_UP 8'h52
`define CH_STATUS_LO 8'h72
`define CH_MON_UP 8'h59
`define CH_MON_LO 8'h79
`define CH_TYPE_0 8'h53
`define CH_TYPE_1 8'h54
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
// Status payload layout
`define PAYLOAD_BYTES 20
`define MODE_BIT_STOP 1
`define MODE_BIT_RUN 2
`define MODE_BIT_PAUSE 3
`define MODE_BIT_DEBUG 4
`define CONN_BIT_LOCAL 0
`define CONN_BIT_REMOTE 1
// Processor type code: arbitrary neutral value
`define CPU_TYPE_CODE 8'h5A
// Error code sent when the registration number is out of range: arbitrary
`define ERR_BAD_REG_NO 16'h0001
// Monitor data limit in bytes
`define MON_MAX_BYTES 8
// Body register width in bits and character counts
`define BODY_BITS 176
`define BODY_CHARS_STATUS 8'h28
`define BODY_CHARS_ERROR 8'h04
// Reply FIFO
`define TX_FIFO_DEPTH 32
`define TX_FIFO_WIDTH 8

`endif

/* File: core/resp_pkg.sv */
// Types and helper functions of the serial status and monitor responder.
// Assumes nothing of its surroundings.
`default_nettype none

package resp_pkg;

   typedef enum logic [1:0] {
      OP_STOP = 2'b00,
      OP_RUN = 2'b01,
      OP_PAUSE = 2'b10,
      OP_DEBUG = 2'b11
   } op_mode_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0000,
      RX_STN0 = 4'b0001,
      RX_STN1 = 4'b0010,
      RX_CMD = 4'b0011,
      RX_ARG0 = 4'b0100,
      RX_ARG1 = 4'b0101,
      RX_TAIL = 4'b0110,
      RX_BCC0 = 4'b0111,
      RX_BCC1 = 4'b1000
   } rx_state_t;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0000,
      TX_WAIT = 4'b0001,
      TX_HEAD = 4'b0010,
      TX_STN0 = 4'b0011,
      TX_STN1 = 4'b0100,
      TX_CMD = 4'b0101,
      TX_ARG0 = 4'b0110,
      TX_ARG1 = 4'b0111,
      TX_BODY = 4'b1000,
      TX_ETX = 4'b1001,
      TX_BCC0 = 4'b1010,
      TX_BCC1 = 4'b1011
   } tx_state_t;

   // Upper-case ASCII hex digit of a nibble
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

endpackage

`default_nettype wire

/* File: core/serial_responder.sv */
// Serial status and monitor responder: parses request frames from the
// character receiver and queues reply frames for the character sender.
// Assumes a character layer that hands over one byte per rx_valid pulse.
//
// What this block does
// - Request sum is low byte of ENQ..EOT, sent as two ASCII hex chars.
// - Lowercase ACK reply appends low byte of sum ACK..ETX as ASCII hex.
// - Payload is 20 binary bytes, each sent as two ASCII hex characters.
// - Mode byte bit1 stop, bit2 run, bit3 pause, bit4 debug.
// - Failed status read answers NAK, station, letter, type, error code, ETX, sum.
// - Error code is two bytes sent as four ASCII hex characters.
// - Good monitor answers ACK, station, letter, number, blocks, count, data, ETX.
// - Failed monitor answers NAK, station, letter, number, error code, ETX, check.
// - Status payload samples present operating state and flags when served.
`default_nettype none
`include "resp_params.svh"

module serial_responder (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic [4:0] station_id,
   input wire logic [7:0] version_no,
   input wire resp_pkg::op_mode_t op_mode,
   input wire logic local_link,
   input wire logic remote_link,
   input wire logic [127:0] flag_list,
   input wire logic status_fail,
   input wire logic [15:0] status_err_code,
   output logic mon_req,
   output logic [3:0] mon_reg_no,
   input wire logic mon_done,
   input wire logic mon_ok,
   input wire logic [15:0] mon_err_code,
   input wire logic [7:0] mon_blocks,
   input wire logic [7:0] mon_count,
   input wire logic [63:0] mon_data,
   output logic status_served,
   output logic bcc_error
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_a_q;
   logic rst_n_s;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_a_q <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n_s <= rst_a_q;
      end
   end

   // ----------------------------------------------------------------
   // Request parser
   // ----------------------------------------------------------------
   resp_pkg::rx_state_t rs_q;
   logic [7:0] cmd_q;
   logic [7:0] arg0_q;
   logic [7:0] arg1_q;
   logic [7:0] rsum_q;
   logic [7:0] rbcc_hi_q;
   logic stn_ok_q;
   logic go_q;
   logic [7:0] stn_hi;
   logic [7:0] stn_lo;
   logic lower_cmd;
   logic is_status;
   logic tx_idle;

   assign stn_hi = resp_pkg::hex_char({3'h0, station_id[4]});
   assign stn_lo = resp_pkg::hex_char(station_id[3:0]);
   assign lower_cmd = (cmd_q == `CH_STATUS_LO) || (cmd_q == `CH_MON_LO);
   assign is_status = (cmd_q == `CH_STATUS_UP) || (cmd_q == `CH_STATUS_LO);

   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         rs_q <= resp_pkg::RX_IDLE;
         cmd_q <= 8'h00;
         arg0_q <= 8'h00;
         arg1_q <= 8'h00;
         rsum_q <= 8'h00;
         rbcc_hi_q <= 8'h00;
         stn_ok_q <= 1'b0;
         go_q <= 1'b0;
         bcc_error <= 1'b0;
      end else begin
         go_q <= 1'b0;
         bcc_error <= 1'b0;
         if (rx_valid) begin
            rsum_q <= rsum_q + rx_data;
            if (rx_data == `CH_ENQ) begin
               // A header always restarts the parse, dropping any partial frame
               rs_q <= resp_pkg::RX_STN0;
               rsum_q <= rx_data;
            end else begin
               unique case (rs_q)
                  resp_pkg::RX_IDLE: begin
                     rs_q <= resp_pkg::RX_IDLE;
                  end
                  resp_pkg::RX_STN0: begin
                     stn_ok_q <= (rx_data == stn_hi);
                     rs_q <= resp_pkg::RX_STN1;
                  end
                  resp_pkg::RX_STN1: begin
                     stn_ok_q <= stn_ok_q && (rx_data == stn_lo);
                     rs_q <= resp_pkg::RX_CMD;
                  end
                  resp_pkg::RX_CMD: begin
                     cmd_q <= rx_data;
                     if (rx_data == `CH_STATUS_UP || rx_data == `CH_STATUS_LO ||
                         rx_data == `CH_MON_UP || rx_data == `CH_MON_LO) begin
                        rs_q <= resp_pkg::RX_ARG0;
                     end else begin
                        rs_q <= resp_pkg::RX_IDLE;
                     end
                  end
                  resp_pkg::RX_ARG0: begin
                     arg0_q <= rx_data;
                     rs_q <= resp_pkg::RX_ARG1;
                  end
                  resp_pkg::RX_ARG1: begin
                     arg1_q <= rx_data;
                     rs_q <= resp_pkg::RX_TAIL;
                     if (is_status && (arg0_q != `CH_TYPE_0 || rx_data != `CH_TYPE_1)) begin
                        rs_q <= resp_pkg::RX_IDLE;
                     end
                  end
                  resp_pkg::RX_TAIL: begin
                     if (rx_data != `CH_EOT) begin
                        rs_q <= resp_pkg::RX_IDLE;
                     end else if (lower_cmd) begin
                        rs_q <= resp_pkg::RX_BCC0;
                     end else begin
                        rs_q <= resp_pkg::RX_IDLE;
                        go_q <= stn_ok_q && tx_idle;
                     end
                  end
                  resp_pkg::RX_BCC0: begin
                     rbcc_hi_q <= rx_data;
                     rs_q <= resp_pkg::RX_BCC1;
                  end
                  resp_pkg::RX_BCC1: begin
                     rs_q <= resp_pkg::RX_IDLE;
                     // Sum is frozen: the check characters follow EOT
                     if (rbcc_hi_q == resp_pkg::hex_char(rsum_q[7:4]) &&
                         rx_data == resp_pkg::hex_char(rsum_q[3:0])) begin
                        go_q <= stn_ok_q && tx_idle;
                     end else begin
                        bcc_error <= stn_ok_q;
                     end
                  end
                  default: begin
                     rs_q <= resp_pkg::RX_IDLE;
                  end
               endcase
               if (rs_q == resp_pkg::RX_BCC0 || rs_q == resp_pkg::RX_BCC1) begin
                  rsum_q <= rsum_q;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Reply builder
   // ----------------------------------------------------------------
   resp_pkg::tx_state_t ts_q;
   logic ack_q;
   logic [`BODY_BITS-1:0] body_q;
   logic [7:0] chars_q;
   logic [7:0] tsum_q;
   logic [7:0] mode_byte;
   logic [7:0] conn_byte;
   logic [159:0] payload;
   logic [3:0] mon_len;
   logic reg_ok;
   byte_stream_if #(.WIDTH(`TX_FIFO_WIDTH)) push_s ();
   byte_stream_if #(.WIDTH(`TX_FIFO_WIDTH)) out_s ();

   assign tx_idle = (ts_q == resp_pkg::TX_IDLE);
   assign reg_ok = (arg0_q == `CH_ZERO) && (arg1_q >= `CH_ZERO) && (arg1_q <= `CH_NINE);

   always_comb begin
      mode_byte = 8'h00;
      mode_byte[`MODE_BIT_STOP] = (op_mode == resp_pkg::OP_STOP);
      mode_byte[`MODE_BIT_RUN] = (op_mode == resp_pkg::OP_RUN);
      mode_byte[`MODE_BIT_PAUSE] = (op_mode == resp_pkg::OP_PAUSE);
      mode_byte[`MODE_BIT_DEBUG] = (op_mode == resp_pkg::OP_DEBUG);
      conn_byte = 8'h00;
      conn_byte[`CONN_BIT_LOCAL] = local_link;
      conn_byte[`CONN_BIT_REMOTE] = remote_link;
   end

   assign payload = {`CPU_TYPE_CODE, version_no, mode_byte, conn_byte, flag_list};
   // Longer monitor data is cut to MON_MAX_BYTES, the eight bytes of mon_data
   assign mon_len = (mon_count > 8'(`MON_MAX_BYTES)) ? 4'(`MON_MAX_BYTES) : mon_count[3:0];

   always_comb begin
      push_s.data = 8'h00;
      unique case (ts_q)
         resp_pkg::TX_IDLE, resp_pkg::TX_WAIT: push_s.data = 8'h00;
         resp_pkg::TX_HEAD: push_s.data = ack_q ? `CH_ACK : `CH_NAK;
         resp_pkg::TX_STN0: push_s.data = stn_hi;
         resp_pkg::TX_STN1: push_s.data = stn_lo;
         resp_pkg::TX_CMD: push_s.data = cmd_q;
         resp_pkg::TX_ARG0: push_s.data = arg0_q;
         resp_pkg::TX_ARG1: push_s.data = arg1_q;
         resp_pkg::TX_BODY: push_s.data = resp_pkg::hex_char(body_q[`BODY_BITS-1 -: 4]);
         resp_pkg::TX_ETX: push_s.data = `CH_ETX;
         resp_pkg::TX_BCC0: push_s.data = resp_pkg::hex_char(tsum_q[7:4]);
         resp_pkg::TX_BCC1: push_s.data = resp_pkg::hex_char(tsum_q[3:0]);
         default: push_s.data = 8'h00;
      endcase
   end

   assign push_s.valid = !(ts_q == resp_pkg::TX_IDLE || ts_q == resp_pkg::TX_WAIT);

   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ts_q <= resp_pkg::TX_IDLE;
         ack_q <= 1'b0;
         body_q <= '0;
         chars_q <= 8'h00;
         mon_req <= 1'b0;
         mon_reg_no <= 4'h0;
         status_served <= 1'b0;
      end else begin
         mon_req <= 1'b0;
         status_served <= 1'b0;
         unique case (ts_q)
            resp_pkg::TX_IDLE: begin
               if (go_q && is_status) begin
                  ack_q <= !status_fail;
                  status_served <= 1'b1;
                  ts_q <= resp_pkg::TX_HEAD;
                  if (!status_fail) begin
                     body_q <= {payload, 16'h0000};
                     chars_q <= `BODY_CHARS_STATUS;
                  end else begin
                     body_q <= {status_err_code, 160'h0};
                     chars_q <= `BODY_CHARS_ERROR;
                  end
               end else if (go_q && reg_ok) begin
                  mon_req <= 1'b1;
                  mon_reg_no <= arg1_q[3:0];
                  ts_q <= resp_pkg::TX_WAIT;
               end else if (go_q) begin
                  ack_q <= 1'b0;
                  body_q <= {`ERR_BAD_REG_NO, 160'h0};
                  chars_q <= `BODY_CHARS_ERROR;
                  ts_q <= resp_pkg::TX_HEAD;
               end
            end
            resp_pkg::TX_WAIT: begin
               if (mon_done) begin
                  ack_q <= mon_ok;
                  ts_q <= resp_pkg::TX_HEAD;
                  if (mon_ok) begin
                     body_q <= {mon_blocks, mon_count[7:4], mon_len, mon_data, 96'h0};
                     chars_q <= 8'h04 + {3'h0, mon_len, 1'b0};
                  end else begin
                     body_q <= {mon_err_code, 160'h0};
                     chars_q <= `BODY_CHARS_ERROR;
                  end
               end
            end
            default: begin
               if (push_s.ready) begin
                  unique case (ts_q)
                     resp_pkg::TX_HEAD: ts_q <= resp_pkg::TX_STN0;
                     resp_pkg::TX_STN0: ts_q <= resp_pkg::TX_STN1;
                     resp_pkg::TX_STN1: ts_q <= resp_pkg::TX_CMD;
                     resp_pkg::TX_CMD: ts_q <= resp_pkg::TX_ARG0;
                     resp_pkg::TX_ARG0: ts_q <= resp_pkg::TX_ARG1;
                     resp_pkg::TX_ARG1: ts_q <= resp_pkg::TX_BODY;
                     resp_pkg::TX_BODY: begin
                        body_q <= {body_q[`BODY_BITS-5:0], 4'h0};
                        chars_q <= chars_q - 8'h01;
                        if (chars_q == 8'h01) begin
                           ts_q <= resp_pkg::TX_ETX;
                        end
                     end
                     resp_pkg::TX_ETX: begin
                        ts_q <= lower_cmd ? resp_pkg::TX_BCC0 : resp_pkg::TX_IDLE;
                     end
                     resp_pkg::TX_BCC0: ts_q <= resp_pkg::TX_BCC1;
                     default: ts_q <= resp_pkg::TX_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   // Running sum of the reply from header through ETX
   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         tsum_q <= 8'h00;
      end else if (push_s.valid && push_s.ready) begin
         if (ts_q == resp_pkg::TX_HEAD) begin
            tsum_q <= push_s.data;
         end else if (ts_q != resp_pkg::TX_BCC0 && ts_q != resp_pkg::TX_BCC1) begin
            tsum_q <= tsum_q + push_s.data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reply FIFO
   // ----------------------------------------------------------------
   // Back-pressure from the sender stalls the builder through push_s.ready
   reply_fifo #(.WIDTH(`TX_FIFO_WIDTH), .DEPTH(`TX_FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n_s),
      .in_s(push_s),
      .out_s(out_s),
      .full(),
      .empty()
   );

   assign out_s.ready = tx_ready;
   assign tx_data = out_s.data;
   assign tx_valid = out_s.valid;

endmodule

`default_nettype wire

/* File: verif/host_model.sv */
// Host computer model: sends request frames, collects reply characters.
// Assumes the bench builds whole frames; stall makes the host slow.
`default_nettype none

module host_model (
   input wire logic clock,
   output logic [7:0] rx_data = 8'h00,
   output logic rx_valid = 1'b0,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   bit stall = 1'b0;

   // One character per cycle; the idle line shows the inverse, not a stale copy
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(posedge clock);
         rx_data <= f[i];
         rx_valid <= 1'b1;
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
   endtask

   always @(posedge clock) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      tx_ready <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
   end
endmodule

`default_nettype wire

/* File: verif/serial_responder_chk.sv */
// Port-level checks of the serial responder, attached by bind.
// Assumes the top module's port names and one clock domain.
`default_nettype none
`include "resp_params.svh"

module serial_responder_chk (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic mon_req,
   input wire logic [3:0] mon_reg_no,
   input wire logic status_served,
   input wire logic bcc_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_tx_held_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply character lost or changed while stalled");
   a_tx_ascii_only: assert property (tx_valid |-> tx_data inside {`CH_ACK, `CH_NAK, `CH_ETX,
      [8'h30:8'h39], [8'h41:8'h46], `CH_STATUS_UP, `CH_STATUS_LO, `CH_MON_UP, `CH_MON_LO,
      `CH_TYPE_0, `CH_TYPE_1})
      else $error("reply character outside the frame alphabet");
   a_mon_req_pulse: assert property (mon_req |=> !mon_req)
      else $error("monitor request longer than one cycle");
   a_mon_reg_range: assert property (mon_req |-> mon_reg_no <= 4'h9)
      else $error("monitor request with registration number above nine");
   a_mon_req_cause: assert property (mon_req |-> $past(rx_valid, 2))
      else $error("monitor request not two cycles after a received character");
   a_served_pulse: assert property (status_served |=> !status_served)
      else $error("status sample pulse longer than one cycle");
   a_served_reply: assert property (status_served |-> ##[1:8] tx_valid)
      else $error("no reply character after status was sampled");
   a_bcc_pulse: assert property (bcc_error |=> !bcc_error)
      else $error("checksum error pulse longer than one cycle");
   a_bcc_cause: assert property (bcc_error |->
      $past(rx_valid, 1) || $past(rx_valid, 2) || $past(rx_valid, 3))
      else $error("checksum error without a recent received character");
endmodule

bind serial_responder serial_responder_chk chk (.clock(clock), .reset_n(reset_n),
   .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .mon_req(mon_req), .mon_reg_no(mon_reg_no),
   .status_served(status_served), .bcc_error(bcc_error));

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench of the serial responder with a frame reference model.
// Assumes host_model as the far side and the checker bound to the top.
`default_nettype none
`include "resp_params.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock = 1'b0, reset_n = 1'b0;
   logic [7:0] rx_data, tx_data, version_no = 8'h00, mon_blocks = 8'h00, mon_count = 8'h00;
   logic rx_valid, tx_valid, tx_ready, mon_req, status_served, bcc_error;
   logic [4:0] station_id = 5'h00;
   resp_pkg::op_mode_t op_mode = resp_pkg::OP_STOP;
   logic local_link = 1'b0, remote_link = 1'b0, status_fail = 1'b0;
   logic mon_done = 1'b0, mon_ok = 1'b0;
   logic [127:0] flag_list = 128'h0;
   logic [15:0] status_err_code = 16'h0, mon_err_code = 16'h0;
   logic [63:0] mon_data = 64'h0;
   logic [3:0] mon_reg_no;
   logic [7:0] fq[$], req_q[$], exp_q[$];
   int err_count = 0, n_compared = 0, cycles = 0, served_n = 0, bcc_n = 0;

   serial_responder uut (.clock(clock), .reset_n(reset_n), .rx_data(rx_data),
      .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .station_id(station_id), .version_no(version_no), .op_mode(op_mode),
      .local_link(local_link), .remote_link(remote_link), .flag_list(flag_list),
      .status_fail(status_fail), .status_err_code(status_err_code), .mon_req(mon_req),
      .mon_reg_no(mon_reg_no), .mon_done(mon_done), .mon_ok(mon_ok),
      .mon_err_code(mon_err_code), .mon_blocks(mon_blocks), .mon_count(mon_count),
      .mon_data(mon_data), .status_served(status_served), .bcc_error(bcc_error));
   host_model host (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

   initial forever #2 clock = ~clock;

   always @(posedge clock) begin
      cycles <= cycles + 1;
      served_n <= served_n + int'(status_served === 1'b1);
      bcc_n <= bcc_n + int'(bcc_error === 1'b1);
      if (cycles == 30000) begin
         err_count++;
         results();
      end
   end

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ---------------------------------------------------------------
   // Reference frame builder
   // ---------------------------------------------------------------
   function automatic logic [7:0] asc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction
   function automatic void hx(input logic [7:0] b);
      fq.push_back(asc(b[7:4]));
      fq.push_back(asc(b[3:0]));
   endfunction
   function automatic void head(input logic [7:0] h, input logic [7:0] cmd);
      fq.delete();
      fq.push_back(h);
      hx({3'h0, station_id});
      fq.push_back(cmd);
   endfunction
   // Sum runs over everything queued so far, header through tail
   function automatic void close(input logic [7:0] tail, input bit lo);
      logic [7:0] s = 8'h00;
      fq.push_back(tail);
      foreach (fq[i]) s += fq[i];
      if (lo) hx(s);
   endfunction

   task automatic xfer(input bit want);
      host.send(req_q);
      for (int i = 0; i < 600 && host.got.size() < exp_q.size(); i++) @(posedge clock);
      repeat (40) @(posedge clock);
      check(16'(host.got.size()), want ? 16'(exp_q.size()) : 16'h0);
      if (want) foreach (exp_q[i]) check({8'h0, host.got[i]}, {8'h0, exp_q[i]});
      host.got.delete();
   endtask

   task automatic status(input bit lo, input bit fail, input bit bad_sum, input bit other);
      logic [7:0] cmd = lo ? `CH_STATUS_LO : `CH_STATUS_UP;
      @(posedge clock);
      station_id <= 5'($urandom_range(0, 31));
      version_no <= 8'($urandom);
      flag_list <= {$urandom, $urandom, $urandom, $urandom};
      {local_link, remote_link} <= 2'($urandom);
      status_fail <= fail;
      status_err_code <= 16'($urandom);
      @(posedge clock);
      head(`CH_ENQ, cmd);
      if (other) fq[2] = fq[2] ^ 8'h01;
      fq.push_back(`CH_TYPE_0);
      fq.push_back(`CH_TYPE_1);
      close(`CH_EOT, lo);
      if (bad_sum) fq[fq.size()-1] = asc(fq[fq.size()-1][3:0] + 4'h1);
      req_q = fq;
      head(fail ? `CH_NAK : `CH_ACK, cmd);
      fq.push_back(`CH_TYPE_0);
      fq.push_back(`CH_TYPE_1);
      if (fail) begin
         hx(status_err_code[15:8]);
         hx(status_err_code[7:0]);
      end else begin
         hx(`CPU_TYPE_CODE);
         hx(version_no);
         hx(8'h02 << op_mode);
         hx({6'h0, remote_link, local_link});
         for (int i = 0; i < 16; i++) hx(flag_list[127-8*i -: 8]);
      end
      close(`CH_ETX, lo);
      exp_q = fq;
   endtask

   task automatic monitor(input bit lo, input logic [7:0] a0, input logic [7:0] a1,
                          input bit ok, input bit served);
      logic [7:0] cmd = lo ? `CH_MON_LO : `CH_MON_UP;
      int cnt = $urandom_range(0, 8);
      head(`CH_ENQ, cmd);
      fq.push_back(a0);
      fq.push_back(a1);
      close(`CH_EOT, lo);
      req_q = fq;
      head(ok ? `CH_ACK : `CH_NAK, cmd);
      fq.push_back(a0);
      fq.push_back(a1);
      fork
         host.send(req_q);
         if (served) begin
            for (int i = 0; i < 100 && mon_req !== 1'b1; i++) @(posedge clock);
            check({12'h0, mon_reg_no}, {12'h0, a1[3:0]});
            mon_done <= 1'b1;
            mon_ok <= ok;
            mon_blocks <= 8'($urandom);
            mon_count <= 8'(cnt);
            mon_data <= {$urandom, $urandom};
            mon_err_code <= 16'($urandom);
            @(posedge clock);
            mon_done <= 1'b0;
         end
      join
      if (!served) begin
         hx(8'h00);
         hx(8'(`ERR_BAD_REG_NO));
      end else if (ok) begin
         hx(mon_blocks);
         hx(mon_count);
         for (int i = 0; i < cnt; i++) hx(mon_data[63-8*i -: 8]);
      end else begin
         hx(mon_err_code[15:8]);
         hx(mon_err_code[7:0]);
      end
      close(`CH_ETX, lo);
      exp_q = fq;
      req_q.delete();
      xfer(1'b1);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(50508));
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         op_mode <= resp_pkg::op_mode_t'(i[1:0]);
         host.stall = i[2];
         status(i[0], 1'b0, 1'b0, 1'b0);
         xfer(1'b1);
      end
      check(16'(served_n), 16'h8);
      status(1'b1, 1'b1, 1'b0, 1'b0);
      xfer(1'b1);
      status(1'b0, 1'b1, 1'b0, 1'b0);
      xfer(1'b1);
      status(1'b1, 1'b0, 1'b1, 1'b0);
      xfer(1'b0);
      check(16'(bcc_n), 16'h1);
      status(1'b0, 1'b0, 1'b0, 1'b1);
      xfer(1'b0);
      monitor(1'b1, 8'h30, 8'h31, 1'b1, 1'b1);
      monitor(1'b0, 8'h30, 8'h39, 1'b1, 1'b1);
      monitor(1'b1, 8'h30, 8'h35, 1'b0, 1'b1);
      monitor(1'b1, 8'h31, 8'h30, 1'b0, 1'b0);
      results();
   end
endmodule

`default_nettype wire
